/* File: common/tim_pkg.sv */
package tim_pkg;
  // Bus carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tim_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tim_axi_rsp_t;
  localparam logic [1:0] TIM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TIM_RESP_SLVERR = 2'h2;
  // Register map
  localparam logic [7:0] TIM_OFS_CTL = 8'h00;
  localparam logic [7:0] TIM_OFS_CLK = 8'h04;
  localparam logic [7:0] TIM_OFS_RLD = 8'h08;
  localparam logic [7:0] TIM_OFS_CNT = 8'h0C;
  localparam logic [15:0] TIM_CTL_RST = 16'h0200;
  localparam logic [15:0] TIM_CLK_RST = 16'h0000;
  localparam logic [15:0] TIM_RLD_RST = 16'hFFFF;
  localparam logic [15:0] TIM_CNT_RST = 16'hFFFF;
  localparam logic [15:0] TIM_CTL_WMASK = 16'h07FF;
  localparam logic [15:0] TIM_CLK_WMASK = 16'h0FEF;
  // timer_control fields
  localparam int TIM_B_EN = 0;
  localparam int TIM_B_RST = 1;
  localparam int TIM_B_MODE = 2;
  localparam int TIM_B_INPUT_POLARITY = 4;
  localparam int TIM_B_DIR = 5;
  localparam int TIM_B_OEN = 6;
  localparam int TIM_B_RLD = 7;
  localparam int TIM_B_FBYP = 8;
  localparam int TIM_B_PD = 9;
  localparam int TIM_B_OPOL = 10;
  localparam int TIM_B_CREQ = 12;
  // timer_clock_event_control fields
  localparam int TIM_B_TSEL = 0;
  localparam int TIM_B_EDGE = 5;
  localparam int TIM_B_EVSRC = 7;
  localparam int TIM_B_FSEL = 8;
  localparam logic [15:0] TIM_CNT_MIN = 16'h0000;
  localparam logic [15:0] TIM_CNT_MAX = 16'hFFFF;
  localparam int TIM_PRE_W = 7;
  typedef enum logic [1:0] {
    TIM_M_TIMER = 2'h0,
    TIM_M_EVENT = 2'h1,
    TIM_M_ONESHOT = 2'h2,
    TIM_M_MEAS = 2'h3
  } tim_mode_t;
  typedef enum logic [1:0] {
    TIM_E_FALL = 2'h0,
    TIM_E_RISE = 2'h1,
    TIM_E_BOTH = 2'h2,
    TIM_E_NONE = 2'h3
  } tim_edge_t;
  typedef enum logic [1:0] {
    TIM_ST_STOP = 2'h0,
    TIM_ST_ARM = 2'h1,
    TIM_ST_RUN = 2'h3
  } tim_state_t;
endpackage

/* File: hdl/tim_channel.sv */
`timescale 1ns/1ps
module tim_channel (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register bus
  input wire tim_pkg::tim_axi_req_t i_axi,
  output tim_pkg::tim_axi_rsp_t o_axi,
  // Pins and chaining
  input wire logic i_timer_input_pin,
  input wire logic i_prev_ovf,
  output logic o_timer_output_pin,
  output logic o_ovf_pulse,
  output logic o_irq_event
);
  import tim_pkg::*;

  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [15:0] w_data_r;
  logic [1:0] w_strb_r;
  logic [15:0] ctl_r;
  logic [15:0] clk_r;
  logic [15:0] reload_r;
  logic [15:0] cnt_r;
  logic [15:0] meas_r;
  tim_state_t st_r;
  logic out_lvl_r;
  logic blk_r;
  logic lvl_q_r;
  logic wr_go;
  logic wr_ctl;
  logic wr_clk;
  logic wr_rld;
  logic [15:0] ctl_nxt;
  logic [15:0] clk_nxt;
  logic [15:0] rld_nxt;
  logic tick;
  logic ftick;
  logic act_in;
  logic lvl;
  logic rise;
  logic fall;
  tim_mode_t mode;
  tim_edge_t edge_sel;
  logic sel_edge;
  logic tstep;
  logic estep;
  logic os_start;
  logic run;
  logic evt;

  assign o_axi = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                   bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                   rdata: rdata_r, rresp: rresp_r};

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0] strb);
    merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write address and data taken in either order
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      awready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_axi.awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b1;
      aw_addr_r <= i_axi.awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end else if (bvalid_r && i_axi.bready) begin
      awready_r <= 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wready_r <= 1'b1;
      w_hold_r <= 1'b0;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'h0;
    end else if (i_axi.wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b1;
      w_data_r <= i_axi.wdata[15:0];
      w_strb_r <= i_axi.wstrb[1:0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end else if (bvalid_r && i_axi.bready) begin
      wready_r <= 1'b1;
    end
  end

  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ctl = wr_go && aw_addr_r == TIM_OFS_CTL;
  assign wr_clk = wr_go && aw_addr_r == TIM_OFS_CLK;
  assign wr_rld = wr_go && aw_addr_r == TIM_OFS_RLD;
  assign ctl_nxt = merge(ctl_r, w_data_r, w_strb_r) & TIM_CTL_WMASK;
  assign clk_nxt = merge(clk_r, w_data_r, w_strb_r) & TIM_CLK_WMASK;
  assign rld_nxt = merge(reload_r, w_data_r, w_strb_r);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= TIM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_ctl || wr_clk || wr_rld || aw_addr_r == TIM_OFS_CNT) ?
                 TIM_RESP_OKAY : TIM_RESP_SLVERR;
    end else if (bvalid_r && i_axi.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel, one cycle after address taken
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= TIM_RESP_OKAY;
    end else if (i_axi.arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= TIM_RESP_OKAY;
      unique case (i_axi.araddr)
        TIM_OFS_CTL: begin
          rdata_r <= {16'h0000, ctl_r};
          rdata_r[TIM_B_CREQ] <= st_r != TIM_ST_STOP;
        end
        TIM_OFS_CLK: rdata_r <= {16'h0000, clk_r};
        TIM_OFS_RLD: rdata_r <= {16'h0000, reload_r};
        TIM_OFS_CNT: rdata_r <= {16'h0000, cnt_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= TIM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && i_axi.rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Control register with hardware clears of reset and enable
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_r <= TIM_CTL_RST;
    end else if (wr_ctl) begin
      ctl_r <= ctl_nxt;
    end else begin
      if (ctl_r[TIM_B_RST]) begin
        ctl_r[TIM_B_RST] <= 1'b0;
        ctl_r[TIM_B_EN] <= 1'b0;
      end
      if (os_start) begin
        ctl_r[TIM_B_EN] <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_r <= TIM_CLK_RST;
      reload_r <= TIM_RLD_RST;
    end else begin
      if (wr_clk) begin
        clk_r <= clk_nxt;
      end
      if (wr_rld) begin
        reload_r <= rld_nxt;
      end
    end
  end

  assign mode = tim_mode_t'(ctl_r[TIM_B_MODE +: 2]);
  assign edge_sel = tim_edge_t'(clk_r[TIM_B_EDGE +: 2]);
  assign act_in = ~(i_timer_input_pin ^ ctl_r[TIM_B_INPUT_POLARITY]);

  tim_prescale #(.W(TIM_PRE_W)) u_timer_clock_select (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(!ctl_r[TIM_B_PD]),
    .i_sel(clk_r[TIM_B_TSEL +: 4]),
    .o_tick(tick)
  );
  tim_prescale #(.W(TIM_PRE_W)) u_filter_clock_select (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_run(!ctl_r[TIM_B_PD]),
    .i_sel(clk_r[TIM_B_FSEL +: 4]),
    .o_tick(ftick)
  );
  tim_filter u_filt (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(ftick),
    .i_bypass(ctl_r[TIM_B_FBYP]),
    .i_in(act_in),
    .o_lvl(lvl)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_q_r <= 1'b0;
    end else begin
      lvl_q_r <= lvl;
    end
  end
  assign rise = lvl && !lvl_q_r;
  assign fall = !lvl && lvl_q_r;

  // Edge field decode shared by event, one-shot and measurement
  always_comb begin
    unique case (edge_sel)
      TIM_E_FALL: sel_edge = fall;
      TIM_E_RISE: sel_edge = rise;
      TIM_E_BOTH: sel_edge = rise || fall;
      TIM_E_NONE: sel_edge = 1'b0;
    endcase
  end

  assign run = st_r == TIM_ST_RUN && !ctl_r[TIM_B_RST];
  assign tstep = tick && !(ctl_r[TIM_B_DIR] && !lvl);
  assign estep = clk_r[TIM_B_EVSRC] ? sel_edge : i_prev_ovf;
  assign os_start = st_r == TIM_ST_ARM && !ctl_r[TIM_B_RST] &&
                    (edge_sel == TIM_E_NONE || sel_edge);

  always_comb begin
    evt = 1'b0;
    if (run) begin
      unique case (mode)
        TIM_M_TIMER: evt = tstep && cnt_r == TIM_CNT_MIN;
        TIM_M_EVENT: evt = estep &&
                           cnt_r == (ctl_r[TIM_B_DIR] ? TIM_CNT_MAX : TIM_CNT_MIN);
        TIM_M_ONESHOT: evt = tick && cnt_r == TIM_CNT_MIN;
        TIM_M_MEAS: evt = sel_edge;
      endcase
    end
  end

  // Run state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= TIM_ST_STOP;
    end else if (ctl_r[TIM_B_RST]) begin
      st_r <= TIM_ST_STOP;
    end else begin
      unique case (st_r)
        TIM_ST_STOP: begin
          if (ctl_r[TIM_B_EN]) begin
            st_r <= (mode == TIM_M_ONESHOT) ? TIM_ST_ARM : TIM_ST_RUN;
          end
        end
        TIM_ST_ARM: begin
          if (os_start) begin
            st_r <= TIM_ST_RUN;
          end else if (!ctl_r[TIM_B_EN]) begin
            st_r <= TIM_ST_STOP;
          end
        end
        TIM_ST_RUN: begin
          if (mode == TIM_M_ONESHOT ? evt : !ctl_r[TIM_B_EN]) begin
            st_r <= TIM_ST_STOP;
          end
        end
        default: st_r <= TIM_ST_STOP;
      endcase
    end
  end

  // Counter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= TIM_CNT_RST;
    end else if (ctl_r[TIM_B_RST]) begin
      cnt_r <= reload_r;
    end else if (run) begin
      unique case (mode)
        TIM_M_TIMER: begin
          if (tstep) begin
            cnt_r <= evt ? (ctl_r[TIM_B_RLD] ? reload_r : TIM_CNT_MAX) :
                     cnt_r - 1'b1;
          end
        end
        TIM_M_EVENT: begin
          if (estep && ctl_r[TIM_B_DIR]) begin
            cnt_r <= evt ? (ctl_r[TIM_B_RLD] ? reload_r : TIM_CNT_MIN) :
                     cnt_r + 1'b1;
          end else if (estep) begin
            cnt_r <= evt ? (ctl_r[TIM_B_RLD] ? reload_r : TIM_CNT_MAX) :
                     cnt_r - 1'b1;
          end
        end
        TIM_M_ONESHOT: begin
          if (tick) begin
            cnt_r <= evt ? reload_r : cnt_r - 1'b1;
          end
        end
        TIM_M_MEAS: begin
          if (evt) begin
            cnt_r <= meas_r;
          end
        end
      endcase
    end
  end

  // Interval counter for measurement mode
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meas_r <= TIM_CNT_MIN;
    end else if (ctl_r[TIM_B_RST] || (run && evt)) begin
      meas_r <= TIM_CNT_MIN;
    end else if (run && tick && mode == TIM_M_MEAS) begin
      meas_r <= meas_r + 1'b1;
    end
  end

  // Pulse level: one-shot pulses, other modes toggle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_lvl_r <= 1'b0;
    end else if (ctl_r[TIM_B_RST] || (st_r == TIM_ST_STOP && !ctl_r[TIM_B_EN])) begin
      out_lvl_r <= 1'b0;
    end else if (os_start) begin
      out_lvl_r <= 1'b1;
    end else if (run && mode != TIM_M_ONESHOT && !ctl_r[TIM_B_EN]) begin
      out_lvl_r <= 1'b0;
    end else if (run && evt) begin
      out_lvl_r <= (mode == TIM_M_ONESHOT) ? 1'b0 : !out_lvl_r;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timer_output_pin <= 1'b0;
    end else begin
      o_timer_output_pin <= ctl_r[TIM_B_OEN] ?
                            (out_lvl_r ^ ctl_r[TIM_B_OPOL]) : 1'b0;
    end
  end

  // Event blocking from reset until the next enable
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blk_r <= 1'b0;
    end else if (ctl_r[TIM_B_RST]) begin
      blk_r <= 1'b1;
    end else if (wr_ctl && ctl_nxt[TIM_B_EN]) begin
      blk_r <= 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_event <= 1'b0;
      o_ovf_pulse <= 1'b0;
    end else begin
      o_irq_event <= evt && !blk_r;
      o_ovf_pulse <= evt && !blk_r && mode != TIM_M_MEAS;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_rst_take;
    ctl_r[TIM_B_RST] && !wr_ctl;
  endsequence

  chk_pin_off: assert property (!ctl_r[TIM_B_OEN] |=> !o_timer_output_pin)
    else $error("output pin not low while disabled");
  chk_reset_load: assert property (s_rst_take |=>
      cnt_r == $past(reload_r) && st_r == TIM_ST_STOP && !ctl_r[TIM_B_EN])
    else $error("reset did not load and stop");
  chk_reset_clear: assert property (s_rst_take |=> !ctl_r[TIM_B_RST])
    else $error("reset bit not self cleared");
  chk_irq_block: assert property (blk_r |=> !o_irq_event)
    else $error("event raised while blocked");
  chk_os_clear: assert property (os_start && !wr_ctl |=>
      st_r == TIM_ST_RUN && !ctl_r[TIM_B_EN])
    else $error("one-shot start kept enable");
  chk_dir_up: assert property (run && mode == TIM_M_EVENT && ctl_r[TIM_B_DIR]
      && estep && cnt_r != TIM_CNT_MAX |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("event up count wrong");
  chk_pause: assert property (run && mode == TIM_M_TIMER && ctl_r[TIM_B_DIR]
      && !lvl |=> $stable(cnt_r))
    else $error("timer ran while paused");
  chk_wrap_down: assert property (run && mode == TIM_M_EVENT && !ctl_r[TIM_B_DIR]
      && !ctl_r[TIM_B_RLD] && estep && cnt_r == TIM_CNT_MIN |=> cnt_r == TIM_CNT_MAX)
    else $error("underflow did not wrap");
  chk_ovf_pulse: assert property (evt && !blk_r |=> o_irq_event
      && o_ovf_pulse == ($past(mode) != TIM_M_MEAS))
    else $error("missing overflow event");
endmodule

/* File: hdl/tim_filter.sv */
`timescale 1ns/1ps
module tim_filter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_tick,
  input wire logic i_bypass,
  // Input level, polarity already applied
  input wire logic i_in,
  output logic o_lvl
);
  logic s0_r;
  logic s1_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s0_r <= 1'b0;
      s1_r <= 1'b0;
    end else if (i_tick) begin
      s0_r <= i_in;
      s1_r <= s0_r;
    end
  end
  // Three agreeing samples move the level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lvl <= 1'b0;
    end else if (i_bypass) begin
      o_lvl <= i_in;
    end else if (i_tick && i_in == s0_r && s0_r == s1_r) begin
      o_lvl <= i_in;
    end
  end
endmodule

/* File: hdl/tim_prescale.sv */
`timescale 1ns/1ps
module tim_prescale #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_run,
  input wire logic [3:0] i_sel,
  // Tick out
  output logic o_tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] mask;
  // Code n ticks once every 2**n clocks; top bit set gives no tick
  assign mask = ~({W{1'b1}} << i_sel[2:0]);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= '0;
    end else if (i_run) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_run && !i_sel[3] && ((cnt_r & mask) == mask);
    end
  end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import tim_pkg::*;
  logic i_clk;
  logic i_arst_n;
  tim_axi_req_t req;
  tim_axi_rsp_t rsp;
  logic pin;
  logic povf;
  logic opin;
  logic ovf;
  logic irq;
  int miscompares;
  int tests_run;
  int novf;
  int nirq;
  int n;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] ent;
  logic [15:0] rdv;
  logic [15:0] seed;
  logic [15:0] cnt;

  tim_channel i_dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_axi(req),
    .o_axi(rsp),
    .i_timer_input_pin(pin),
    .i_prev_ovf(povf),
    .o_timer_output_pin(opin),
    .o_ovf_pulse(ovf),
    .o_irq_event(irq)
  );
  tim_far i_far (
    .i_clk(i_clk),
    .o_pin(pin),
    .o_ovf(povf)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic fail(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Result watcher, mid-cycle where registered outputs are settled
  always @(negedge i_clk) begin
    if (ovf === 1'b1) novf++;
    if (irq === 1'b1) nirq++;
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      rdv = rsp.rdata[15:0];
      ent = rq.pop_front();
      tests_run++;
      if ((rdv & ent[31:16]) !== (ent[15:0] & ent[31:16]) || rsp.rresp !== ent[33:32])
        fail("read data or response");
    end
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
      tests_run++;
      if (rsp.bresp !== bq.pop_front()) fail("write response");
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] r = TIM_RESP_OKAY);
    logic ta;
    logic tw;
    logic tb;
    logic ka;
    logic kw;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    bq.push_back(r);
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!tb) begin
      @(negedge i_clk);
      ka = ta | rsp.awready;
      kw = tw | rsp.wready;
      tb = rsp.bvalid;
      @(posedge i_clk);
      if (ka) req.awvalid <= 1'b0;
      if (kw) req.wvalid <= 1'b0;
      if (tb) req.bready <= 1'b0;
      ta = ka;
      tw = kw;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF,
                    input logic [1:0] r = TIM_RESP_OKAY);
    logic ta;
    logic tb;
    ta = 1'b0;
    tb = 1'b0;
    rq.push_back({r, m, e});
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!tb) begin
      @(negedge i_clk);
      ta = ta | rsp.arready;
      tb = rsp.rvalid;
      @(posedge i_clk);
      if (ta) req.arvalid <= 1'b0;
      if (tb) req.rready <= 1'b0;
    end
  endtask

  task automatic treset(input logic [15:0] base);
    int i;
    wr(TIM_OFS_CTL, base | 16'h0003);
    i = 0;
    do begin
      rd(TIM_OFS_CTL, 16'h0000, 16'h0000);
      i++;
    end while (rdv[TIM_B_RST] !== 1'b0 && i < 20);
    tests_run++;
    if (rdv[1:0] !== 2'b00) fail("reset bit or enable left set");
  endtask

  task automatic run(input logic [15:0] c, input int n, input int w);
    wr(TIM_OFS_CTL, c | 16'h0001);
    if (w == 0) i_far.ovf(n);
    else i_far.pulses(n, w);
    repeat (8) @(posedge i_clk);
    wr(TIM_OFS_CTL, c);
  endtask

  task automatic pc(input logic e);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    tests_run++;
    if (opin !== e) fail("output pin level");
  endtask

  initial begin
    req = '0;
    i_arst_n = 1'b0;
    seed = 16'h9162;
    fork
      begin
        repeat (30000) @(posedge i_clk);
        miscompares++;
        conclude();
      end
    join_none
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(TIM_OFS_CTL, TIM_CTL_RST);
    rd(TIM_OFS_CLK, TIM_CLK_RST);
    rd(TIM_OFS_RLD, TIM_RLD_RST);
    rd(TIM_OFS_CNT, TIM_CNT_RST);
    rd(8'h10, 16'h0000, 16'hFFFF, TIM_RESP_SLVERR);
    wr(8'h14, 16'h1234, TIM_RESP_SLVERR);
    wr(TIM_OFS_CNT, 16'h1234);
    rd(TIM_OFS_CNT, TIM_CNT_RST);
    wr(TIM_OFS_CLK, 16'hFFFF);
    rd(TIM_OFS_CLK, TIM_CLK_WMASK);
    // Event mode, preceding channel as source
    wr(TIM_OFS_CLK, 16'h0020);
    wr(TIM_OFS_RLD, 16'h0010);
    treset(16'h0024);
    rd(TIM_OFS_CNT, 16'h0010);
    cnt = 16'h0010;
    seed = lfsr(seed);
    n = 1 + seed[2:0];
    run(16'h0024, n, 0);
    cnt += 16'(n);
    rd(TIM_OFS_CNT, cnt);
    seed = lfsr(seed);
    n = 1 + seed[2:0];
    run(16'h0004, n, 0);
    cnt -= 16'(n);
    rd(TIM_OFS_CNT, cnt);
    // Pin edges, filter bypassed, every edge code
    // Polarity settles while stopped, so no false edge is counted
    wr(TIM_OFS_CTL, 16'h0134);
    for (int e = 0; e < 4; e++) begin
      wr(TIM_OFS_CLK, 16'h0080 | (16'(e) << 5));
      seed = lfsr(seed);
      n = 1 + seed[1:0];
      run(16'h0134, n, 3);
      cnt += (e == 2) ? 16'(2 * n) : (e == 3) ? 16'h0000 : 16'(n);
      rd(TIM_OFS_CNT, cnt);
    end
    // Filter on: glitch rejected, held pulses pass, reserved rate stalls
    wr(TIM_OFS_CLK, 16'h00A0);
    run(16'h0034, 1, 1);
    rd(TIM_OFS_CNT, cnt);
    run(16'h0034, 2, 12);
    cnt += 16'h0002;
    rd(TIM_OFS_CNT, cnt);
    wr(TIM_OFS_CLK, 16'h08A0);
    run(16'h0034, 2, 12);
    rd(TIM_OFS_CNT, cnt);
    // Underflow wrap, then reload
    wr(TIM_OFS_CLK, 16'h0020);
    wr(TIM_OFS_RLD, 16'h0002);
    treset(16'h0004);
    novf = 0;
    nirq = 0;
    run(16'h0004, 3, 0);
    rd(TIM_OFS_CNT, 16'hFFFF);
    tests_run++;
    if (novf !== 1 || nirq !== 1) fail("wrap event pulses");
    treset(16'h0084);
    run(16'h0084, 3, 0);
    rd(TIM_OFS_CNT, 16'h0002);
    tests_run++;
    if (novf !== 2) fail("reload overflow pulse");
    // Timer mode: reserved clock code, pause on inactive input
    wr(TIM_OFS_CLK, 16'h0008);
    treset(16'h0000);
    run(16'h0000, 5, 0);
    rd(TIM_OFS_CNT, 16'h0002);
    wr(TIM_OFS_CLK, 16'h0000);
    run(16'h0130, 5, 0);
    rd(TIM_OFS_CNT, 16'h0002);
    i_far.level(1'b1);
    run(16'h0120, 5, 0);
    rd(TIM_OFS_CNT, 16'h0002);
    i_far.level(1'b0);
    // Measurement captures on rising edges, then none with the edge code set to none
    wr(TIM_OFS_CLK, 16'h0020);
    nirq = 0;
    novf = 0;
    run(16'h013C, 3, 5);
    rd(TIM_OFS_CNT, 16'h0000, 16'hFFF0);
    wr(TIM_OFS_CLK, 16'h0060);
    run(16'h013C, 3, 5);
    tests_run++;
    if (nirq !== 3 || novf !== 0) fail("capture events");
    // One-shot starts: on enable, then on a rising edge
    wr(TIM_OFS_CTL, 16'h0049);
    rd(TIM_OFS_CTL, 16'h0048, 16'h0FFF);
    wr(TIM_OFS_CLK, 16'h0020);
    wr(TIM_OFS_CTL, 16'h0149);
    rd(TIM_OFS_CTL, 16'h0149, 16'h0FFF);
    i_far.pulses(1, 3);
    rd(TIM_OFS_CTL, 16'h0148, 16'h0FFF);
    // Output pin idle levels
    wr(TIM_OFS_CTL, 16'h0400);
    pc(1'b0);
    wr(TIM_OFS_CTL, 16'h0440);
    pc(1'b1);
    wr(TIM_OFS_CTL, 16'h0040);
    pc(1'b0);
    conclude();
  end
endmodule

/* File: verif/tim_far.sv */
`timescale 1ns/1ps
module tim_far (
  // Clock
  input wire logic i_clk,
  // Pins toward the channel
  output logic o_pin,
  output logic o_ovf
);
  initial begin
    o_pin = 1'b0;
    o_ovf = 1'b0;
  end
  // Pin level, held until changed
  task automatic level(input logic v);
    @(posedge i_clk);
    o_pin <= v;
  endtask
  // Pulses, w plus one cycles high and low
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      level(1'b1);
      repeat (w) @(posedge i_clk);
      level(1'b0);
      repeat (w) @(posedge i_clk);
    end
  endtask
  // Preceding channel overflows, spaced apart
  task automatic ovf(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_ovf <= 1'b1;
      @(posedge i_clk);
      o_ovf <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule
